// *** src/das_defines.svh ***
/*
 * Constants of the dual alarm supervisor: timing, limits, register map,
 * field positions and key indices.
 * Assumes inclusion by the package and by the design modules only.
 */
`ifndef DAS_DEFINES_SVH
`define DAS_DEFINES_SVH

`define DAS_CLK_PERIOD_NS 40
`define DAS_HALF_SEC_NS   500000000
`define DAS_MENU_TIMEOUT_S 4'hA

`define DAS_RATE_MAX  27'h0F_423F
`define DAS_TOTAL_MAX 27'h5F5_E0FF
`define DAS_DELAY_MAX 12'hE10
`define DAS_CODE_OFF  16'h0000
`define DAS_DIGIT_MAX 4'h9

// register offsets and decoded selects
`define DAS_ADR_CTRL  8'h00
`define DAS_ADR_CODE  8'h04
`define DAS_ADR_STAT  8'h08
`define DAS_ADR_CH0   4'h1
`define DAS_ADR_CH1   4'h2
`define DAS_SEL_NONE  4'h0
`define DAS_SEL_CTRL  4'h1
`define DAS_SEL_CODE  4'h2
`define DAS_SEL_STAT  4'h3
`define DAS_SUB_CFG   2'h0
`define DAS_SUB_SP    2'h1
`define DAS_SUB_HYS   2'h2
`define DAS_SUB_TIME  2'h3

// field positions
`define DAS_CFG_EN     0
`define DAS_CFG_TOTAL  1
`define DAS_CFG_LOW    2
`define DAS_CFG_CLOSED 3
`define DAS_CFG_FLASH  4
`define DAS_SIL_LSB    16
`define DAS_ACC_EN     0

// key indices
`define DAS_KEY_PROG  0
`define DAS_KEY_UP    1
`define DAS_KEY_DOWN  2
`define DAS_KEY_ENTER 3

`endif

// *** src/das_pkg.sv ***
/*
 * Types of the dual alarm supervisor: alarm configuration, channel status
 * and state encodings.
 * Assumes das_defines.svh on the include path.
 */
`include "das_defines.svh"

package das_pkg;

	typedef struct packed {
		logic        enable;
		logic        isTotal;
		logic        isLow;
		logic        closedIdle;
		logic        flashEn;
		logic [26:0] setpoint;
		logic [19:0] hysteresis;
		logic [11:0] delay;
		logic [11:0] silence;
	} das_cfg_t;

	typedef struct packed {
		logic active;
		logic annun;
		logic switchClosed;
		logic flashReq;
	} das_stat_t;

	typedef enum logic [3:0] {
		A_IDLE   = 4'b0001,
		A_DELAY  = 4'b0010,
		A_ACTIVE = 4'b0100,
		A_SILENT = 4'b1000
	} das_alm_t;

	typedef enum logic [3:0] {
		M_DISP = 4'b0001,
		M_CODE = 4'b0010,
		M_SP1  = 4'b0100,
		M_SP2  = 4'b1000
	} das_menu_t;

endpackage

// *** src/das_alarm_ch.sv ***
/*
 * One alarm channel: setpoint comparison with hysteresis on rate values, delay and
 * silence timers, annunciator and switch state.
 * Assumes half and one second ticks and accept pulses on mclk.
 */
`timescale 1ns/1ps
`include "das_defines.svh"

module das_alarm_ch
	import das_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire das_cfg_t    cfg,
	input  wire logic [19:0] rateValue,
	input  wire logic [26:0] totalValue,
	input  wire logic        halfTick,
	input  wire logic        secTick,
	input  wire logic        flashPhase,
	input  wire logic        acceptPulse,
	output das_stat_t        stat
);

	das_alm_t    stateFf;
	das_alm_t    nxt_state;
	logic        condFf;
	logic        nxt_cond;
	logic [11:0] cntFf;
	logic [11:0] nxt_cnt;
	logic [27:0] val;
	logic [27:0] sp;
	logic [27:0] hys;
	logic        setHit;
	logic        relHit;

	/**************************************************************/
	/* comparison and timers                                       */
	/**************************************************************/
	always_comb begin
		val = cfg.isTotal ? {1'b0, totalValue} : {8'h00, rateValue};
		sp = {1'b0, cfg.setpoint};
		hys = cfg.isTotal ? 28'h000_0000 : {8'h00, cfg.hysteresis};
		setHit = cfg.isLow ? (val <= sp) : (val >= sp);
		relHit = cfg.isLow ? (val > sp + hys) : (val + hys < sp);
		nxt_cond = condFf;
		if (halfTick) begin
			nxt_cond = condFf ? !relHit : setHit;
		end
		if (!cfg.enable) begin
			nxt_cond = 1'b0;
		end
		nxt_state = stateFf;
		nxt_cnt = cntFf;
		unique case (stateFf)
			A_IDLE: begin
				if (condFf) begin
					nxt_cnt = cfg.delay;
					nxt_state = (cfg.delay == 12'h000) ? A_ACTIVE : A_DELAY;
				end
			end
			A_DELAY: begin
				if (!condFf) begin
					nxt_state = A_IDLE;
				end else if (secTick) begin
					nxt_cnt = cntFf - 12'h001;
					if (cntFf <= 12'h001) begin
						nxt_state = A_ACTIVE;
					end
				end
			end
			A_ACTIVE: begin
				if (!condFf) begin
					nxt_state = A_IDLE;
				end else if (acceptPulse && cfg.silence != 12'h000) begin
					nxt_cnt = cfg.silence;
					nxt_state = A_SILENT;
				end
			end
			A_SILENT: begin
				if (secTick) begin
					nxt_cnt = cntFf - 12'h001;
					if (cntFf <= 12'h001) begin
						nxt_state = condFf ? A_ACTIVE : A_IDLE;
					end
				end
			end
			default: begin
				nxt_state = A_IDLE;
			end
		endcase
		if (!cfg.enable) begin
			nxt_state = A_IDLE;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stateFf <= A_IDLE;
			condFf <= 1'b0;
			cntFf <= 12'h000;
		end else begin
			stateFf <= nxt_state;
			condFf <= nxt_cond;
			cntFf <= nxt_cnt;
		end
	end

	/**************************************************************/
	/* status towards the top                                      */
	/**************************************************************/
	always_comb begin
		stat.active = (stateFf == A_ACTIVE);
		stat.annun = stat.active ||
			((stateFf == A_DELAY || stateFf == A_SILENT) && flashPhase);
		stat.switchClosed = cfg.closedIdle ^ stat.active;
		stat.flashReq = stat.active && cfg.flashEn;
	end

endmodule

// *** src/das_top.sv ***
/*
 * Dual alarm supervisor top: Wishbone register file, tick divider, push
 * button synchronisers, direct setpoint menu and registered outputs.
 * Assumes rate and total values arrive on mclk from the counter core and
 * push buttons arrive asynchronously from pins.
 */
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "das_defines.svh"

module das_top
	import das_pkg::*;
#(
	parameter int unsigned HALF_SEC_CYCLES =
		`DAS_HALF_SEC_NS / `DAS_CLK_PERIOD_NS
)(
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [19:0] rateValue,
	input  wire logic [26:0] totalValue,
	input  wire logic [3:0]  keyPins,
	output logic      [1:0]  alarmSwitchClosed,
	output logic      [1:0]  annunOn,
	output logic      [1:0]  dispLabel,
	output logic      [3:0]  menuPrompt,
	output logic             promptTotal,
	output logic      [15:0] codeDigits,
	output logic      [1:0]  codeCursor
);

	/**************************************************************/
	/* decoding helpers                                            */
	/**************************************************************/
	function automatic logic [3:0] regSel(input logic [7:0] adr);
		logic [3:0] s;
		s = `DAS_SEL_NONE;
		if (adr == `DAS_ADR_CTRL) begin
			s = `DAS_SEL_CTRL;
		end else if (adr == `DAS_ADR_CODE) begin
			s = `DAS_SEL_CODE;
		end else if (adr == `DAS_ADR_STAT) begin
			s = `DAS_SEL_STAT;
		end else if (adr[1:0] == 2'h0 && adr[7:4] == `DAS_ADR_CH0) begin
			s = {2'b10, adr[3:2]};
		end else if (adr[1:0] == 2'h0 && adr[7:4] == `DAS_ADR_CH1) begin
			s = {2'b11, adr[3:2]};
		end
		return s;
	endfunction

	function automatic logic [31:0] byteMerge(input logic [31:0] old,
		input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				m[b*8 +: 8] = wr[b*8 +: 8];
			end
		end
		return m;
	endfunction

	function automatic logic [26:0] clampTo(input logic [26:0] v,
		input logic [26:0] lim);
		return (v > lim) ? lim : v;
	endfunction

	function automatic logic [3:0] digitStep(input logic [3:0] d,
		input logic up);
		logic [3:0] r;
		if (up) begin
			r = (d >= `DAS_DIGIT_MAX) ? 4'h0 : d + 4'h1;
		end else begin
			r = (d == 4'h0) ? `DAS_DIGIT_MAX : d - 4'h1;
		end
		return r;
	endfunction

	/**************************************************************/
	/* declarations                                                */
	/**************************************************************/
	das_cfg_t    cfgFf [2];
	das_cfg_t    nxt_cfg [2];
	das_stat_t   chStat [2];
	logic        accEnFf;
	logic        nxt_accEn;
	logic [15:0] pendCodeFf;
	logic [15:0] nxt_pendCode;
	logic        ackFf;
	logic        nxt_ack;
	logic [31:0] datFf;
	logic [31:0] nxt_dat;
	logic [3:0]  sel;
	logic [31:0] rdWord;
	logic [31:0] merged;
	logic        wbReq;
	logic        wbWr;
	logic [23:0] halfCntFf;
	logic [23:0] nxt_halfCnt;
	logic        halfTickFf;
	logic        nxt_halfTick;
	logic        phaseFf;
	logic        nxt_phase;
	logic        secTick;
	logic [3:0]  keySync1Ff;
	logic [3:0]  keySync2Ff;
	logic [3:0]  keyPrevFf;
	logic [3:0]  keyRise;
	logic        combo;
	logic        accept;
	das_menu_t   menuFf;
	das_menu_t   nxt_menu;
	logic [3:0]  idleSecFf;
	logic [3:0]  nxt_idleSec;
	logic [15:0] bufFf;
	logic [15:0] nxt_buf;
	logic [1:0]  curFf;
	logic [1:0]  nxt_cur;
	logic [15:0] actCodeFf;
	logic [15:0] nxt_actCode;
	logic [1:0]  nxt_sw;
	logic [1:0]  nxt_annun;
	logic [1:0]  nxt_label;
	logic        nxt_pTotal;

	/**************************************************************/
	/* register file over Wishbone                                 */
	/**************************************************************/
	always_comb begin
		wbReq = wb_cyc_i && wb_stb_i && !ackFf;
		// write commits at the edge where the master samples ack high
		wbWr = wb_cyc_i && wb_stb_i && wb_we_i && ackFf;
		sel = regSel(wb_adr_i);
		rdWord = 32'h0000_0000;
		if (sel == `DAS_SEL_CTRL) begin
			rdWord[`DAS_ACC_EN] = accEnFf;
		end else if (sel == `DAS_SEL_CODE) begin
			rdWord[15:0] = pendCodeFf;
		end else if (sel == `DAS_SEL_STAT) begin
			rdWord[15:0] = {menuFf, 2'b00, chStat[1].annun, chStat[0].annun,
				2'b00, chStat[1].switchClosed, chStat[0].switchClosed,
				2'b00, chStat[1].active, chStat[0].active};
		end else if (sel[3]) begin
			unique case (sel[1:0])
				`DAS_SUB_CFG: begin
					rdWord[`DAS_CFG_EN] = cfgFf[sel[2]].enable;
					rdWord[`DAS_CFG_TOTAL] = cfgFf[sel[2]].isTotal;
					rdWord[`DAS_CFG_LOW] = cfgFf[sel[2]].isLow;
					rdWord[`DAS_CFG_CLOSED] = cfgFf[sel[2]].closedIdle;
					rdWord[`DAS_CFG_FLASH] = cfgFf[sel[2]].flashEn;
				end
				`DAS_SUB_SP: begin
					rdWord[26:0] = cfgFf[sel[2]].setpoint;
				end
				`DAS_SUB_HYS: begin
					if (!cfgFf[sel[2]].isTotal) begin
						rdWord[19:0] = cfgFf[sel[2]].hysteresis;
					end
				end
				`DAS_SUB_TIME: begin
					rdWord[11:0] = cfgFf[sel[2]].delay;
					rdWord[`DAS_SIL_LSB +: 12] = cfgFf[sel[2]].silence;
				end
			endcase
		end
		merged = byteMerge(rdWord, wb_dat_i, wb_sel_i);
		nxt_cfg = cfgFf;
		nxt_accEn = accEnFf;
		nxt_pendCode = pendCodeFf;
		nxt_ack = wbReq;
		nxt_dat = wbReq ? rdWord : datFf;
		if (wbWr) begin
			if (sel == `DAS_SEL_CTRL) begin
				nxt_accEn = merged[`DAS_ACC_EN];
			end else if (sel == `DAS_SEL_CODE) begin
				nxt_pendCode = merged[15:0];
			end else if (sel[3]) begin
				unique case (sel[1:0])
					`DAS_SUB_CFG: begin
						if (merged[`DAS_CFG_TOTAL] != cfgFf[sel[2]].isTotal) begin
							// type change restores defaults and disables
							nxt_cfg[sel[2]] = '0;
							nxt_cfg[sel[2]].isTotal = merged[`DAS_CFG_TOTAL];
						end else begin
							nxt_cfg[sel[2]].enable = merged[`DAS_CFG_EN];
							nxt_cfg[sel[2]].isLow = merged[`DAS_CFG_LOW];
							nxt_cfg[sel[2]].closedIdle = merged[`DAS_CFG_CLOSED];
							nxt_cfg[sel[2]].flashEn = merged[`DAS_CFG_FLASH];
						end
					end
					`DAS_SUB_SP: begin
						nxt_cfg[sel[2]].setpoint = clampTo(merged[26:0],
							cfgFf[sel[2]].isTotal ? `DAS_TOTAL_MAX
							: `DAS_RATE_MAX);
					end
					`DAS_SUB_HYS: begin
						if (!cfgFf[sel[2]].isTotal) begin
							nxt_cfg[sel[2]].hysteresis =
								(merged[19:0] > `DAS_RATE_MAX)
								? 20'(`DAS_RATE_MAX) : merged[19:0];
						end
					end
					`DAS_SUB_TIME: begin
						nxt_cfg[sel[2]].delay = (merged[11:0] > `DAS_DELAY_MAX)
							? `DAS_DELAY_MAX : merged[11:0];
						nxt_cfg[sel[2]].silence = merged[`DAS_SIL_LSB +: 12];
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cfgFf[0] <= '0;
			cfgFf[1] <= '0;
			accEnFf <= 1'b0;
			pendCodeFf <= `DAS_CODE_OFF;
			ackFf <= 1'b0;
			datFf <= 32'h0000_0000;
		end else begin
			cfgFf <= nxt_cfg;
			accEnFf <= nxt_accEn;
			pendCodeFf <= nxt_pendCode;
			ackFf <= nxt_ack;
			datFf <= nxt_dat;
		end
	end

	/**************************************************************/
	/* half and one second ticks                                   */
	/**************************************************************/
	always_comb begin
		nxt_halfTick = (halfCntFf >= 24'(HALF_SEC_CYCLES - 1));
		nxt_halfCnt = nxt_halfTick ? 24'h00_0000 : halfCntFf + 24'h00_0001;
		nxt_phase = halfTickFf ? !phaseFf : phaseFf;
		secTick = halfTickFf && phaseFf;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			halfCntFf <= 24'h00_0000;
			halfTickFf <= 1'b0;
			phaseFf <= 1'b0;
		end else begin
			halfCntFf <= nxt_halfCnt;
			halfTickFf <= nxt_halfTick;
			phaseFf <= nxt_phase;
		end
	end

	/**************************************************************/
	/* push buttons                                                */
	/**************************************************************/
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			keySync1Ff <= 4'h0;
			keySync2Ff <= 4'h0;
			keyPrevFf <= 4'h0;
		end else begin
			keySync1Ff <= keyPins;
			keySync2Ff <= keySync1Ff;
			keyPrevFf <= keySync2Ff;
		end
	end

	always_comb begin
		keyRise = keySync2Ff & ~keyPrevFf;
		combo = keySync2Ff[`DAS_KEY_PROG] && keySync2Ff[`DAS_KEY_UP] &&
			(keyRise[`DAS_KEY_PROG] || keyRise[`DAS_KEY_UP]);
		// accept only outside the menu and not as part of the combination
		accept = keyRise[`DAS_KEY_PROG] && !keySync2Ff[`DAS_KEY_UP] &&
			(menuFf == M_DISP);
	end

	/**************************************************************/
	/* alarm channels                                              */
	/**************************************************************/
	generate
		for (genvar n = 0; n < 2; n++) begin : gCh
			das_alarm_ch uCh (
				.mclk        (mclk),
				.arst_n      (arst_n),
				.cfg         (cfgFf[n]),
				.rateValue   (rateValue),
				.totalValue  (totalValue),
				.halfTick    (halfTickFf),
				.secTick     (secTick),
				.flashPhase  (phaseFf),
				.acceptPulse (accept),
				.stat        (chStat[n])
			);
		end
	endgenerate

	/**************************************************************/
	/* direct setpoint menu                                        */
	/**************************************************************/
	always_comb begin
		nxt_menu = menuFf;
		nxt_buf = bufFf;
		nxt_cur = curFf;
		nxt_actCode = actCodeFf;
		nxt_idleSec = idleSecFf;
		if (|keyRise || menuFf == M_DISP) begin
			nxt_idleSec = 4'h0;
		end else if (secTick && idleSecFf < `DAS_MENU_TIMEOUT_S) begin
			nxt_idleSec = idleSecFf + 4'h1;
		end
		unique case (menuFf)
			M_DISP: begin
				nxt_actCode = pendCodeFf;
				nxt_buf = 16'h0000;
				nxt_cur = 2'h0;
				if (combo && accEnFf) begin
					nxt_menu = (actCodeFf == `DAS_CODE_OFF) ? M_SP1 : M_CODE;
				end
			end
			M_CODE: begin
				if (keyRise[`DAS_KEY_UP] || keyRise[`DAS_KEY_DOWN]) begin
					nxt_buf[curFf*4 +: 4] = digitStep(bufFf[curFf*4 +: 4],
						keyRise[`DAS_KEY_UP]);
				end else if (keyRise[`DAS_KEY_PROG]) begin
					nxt_cur = curFf + 2'h1;
				end else if (keyRise[`DAS_KEY_ENTER]) begin
					nxt_menu = (bufFf == actCodeFf) ? M_SP1 : M_DISP;
				end
			end
			M_SP1, M_SP2: begin
				if (keyRise[`DAS_KEY_UP] || keyRise[`DAS_KEY_DOWN]) begin
					nxt_menu = (menuFf == M_SP1) ? M_SP2 : M_SP1;
				end else if (keyRise[`DAS_KEY_ENTER]) begin
					nxt_menu = M_DISP;
				end
			end
			default: begin
				nxt_menu = M_DISP;
			end
		endcase
		if (menuFf != M_DISP && idleSecFf >= `DAS_MENU_TIMEOUT_S) begin
			nxt_menu = M_DISP;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			menuFf <= M_DISP;
			bufFf <= 16'h0000;
			curFf <= 2'h0;
			actCodeFf <= `DAS_CODE_OFF;
			idleSecFf <= 4'h0;
		end else begin
			menuFf <= nxt_menu;
			bufFf <= nxt_buf;
			curFf <= nxt_cur;
			actCodeFf <= nxt_actCode;
			idleSecFf <= nxt_idleSec;
		end
	end

	/**************************************************************/
	/* registered outputs                                          */
	/**************************************************************/
	always_comb begin
		nxt_sw = {chStat[1].switchClosed, chStat[0].switchClosed};
		nxt_annun = {chStat[1].annun, chStat[0].annun};
		// alarm one wins the label slot when both flash at once
		nxt_label = 2'h0;
		if (phaseFf && chStat[0].flashReq) begin
			nxt_label = 2'h1;
		end else if (phaseFf && chStat[1].flashReq) begin
			nxt_label = 2'h2;
		end
		nxt_pTotal = (menuFf == M_SP2) ? cfgFf[1].isTotal
			: cfgFf[0].isTotal;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			alarmSwitchClosed <= 2'h0;
			annunOn <= 2'h0;
			dispLabel <= 2'h0;
			menuPrompt <= M_DISP;
			promptTotal <= 1'b0;
			codeDigits <= 16'h0000;
			codeCursor <= 2'h0;
		end else begin
			alarmSwitchClosed <= nxt_sw;
			annunOn <= nxt_annun;
			dispLabel <= nxt_label;
			menuPrompt <= menuFf;
			promptTotal <= nxt_pTotal;
			codeDigits <= bufFf;
			codeCursor <= curFf;
		end
	end

	assign wb_dat_o = datFf;
	assign wb_ack_o = ackFf;

endmodule

// *** sim/das_chk.sv ***
/*
 * Checker of das_top: bus answer, menu moves, labels, reset state.
 * Assumes only the ports of das_top; bound at the foot.
 */
`timescale 1ns/1ps

module das_chk #(
	parameter int unsigned HALF_SEC_CYCLES = 20
)(
	input wire logic       mclk,
	input wire logic       arst_n,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic [3:0] keyPins,
	input wire logic [1:0] alarmSwitchClosed,
	input wire logic [1:0] annunOn,
	input wire logic [1:0] dispLabel,
	input wire logic [3:0] menuPrompt
);
	// held keys restart it, so it bounds the edge-restarted menu timer
	int unsigned idleCntFf;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			idleCntFf <= 0;
		end else if (menuPrompt == 4'h1 || keyPins != 4'h0) begin
			idleCntFf <= 0;
		end else begin
			idleCntFf <= idleCntFf + 1;
		end
	end

	default clocking @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	AST_ACK_NEXT:
		assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	AST_ACK_PULSE:
		assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_MENU_ONEHOT:
		assert property ($onehot(menuPrompt))
		else $error("menu state not one-hot");
	AST_MENU_OPEN:
		assert property (menuPrompt == 4'h1 ##1 menuPrompt != 4'h1 |->
			menuPrompt inside {4'h2, 4'h4} && $past(keyPins[1:0], 4) == 2'h3)
		else $error("menu opened without program and up");
	AST_CODE_EXIT:
		assert property (menuPrompt == 4'h2 ##1 menuPrompt != 4'h2 |->
			menuPrompt inside {4'h1, 4'h4})
		else $error("code prompt left to a wrong state");
	AST_LABEL_CODE:
		assert property (dispLabel != 2'h3 &&
			(dispLabel != 2'h1 || annunOn[0]) &&
			(dispLabel != 2'h2 || annunOn[1]))
		else $error("label shown without active alarm");
	AST_MENU_TIMEOUT:
		assert property (idleCntFf < 22 * HALF_SEC_CYCLES + 8)
		else $error("menu open too long without keys");
	AST_RESET_STATE:
		assert property ($rose(arst_n) |-> menuPrompt == 4'h1 &&
			alarmSwitchClosed == 2'h0 && annunOn == 2'h0)
		else $error("outputs not cleared by reset");
endmodule

bind das_top das_chk #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) u_das_chk (
	.mclk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .keyPins,
	.alarmSwitchClosed, .annunOn, .dispLabel, .menuPrompt);

// *** sim/das_panel.sv ***
/*
 * Operator panel model: the four front push buttons.
 * Assumes press is called from the bench on the mclk domain.
 */
`timescale 1ns/1ps

module das_panel (
	input  wire logic       mclk,
	output logic      [3:0] keyPins
);
	initial keyPins = 4'h0;

	// release held as long as the press so every edge passes the synchroniser
	task automatic press(input logic [3:0] k);
		@(posedge mclk);
		keyPins <= k;
		repeat (10) @(posedge mclk);
		keyPins <= 4'h0;
		repeat (10) @(posedge mclk);
	endtask
endmodule

// *** sim/test_dual_alarm_supervisor.sv ***
/*
 * Bench of das_top: rate model, delay, silence, menu and registers.
 * Assumes das_top, das_panel and the bound das_chk compiled before it.
 */
`timescale 1ns/1ps

module test_dual_alarm_supervisor;
	localparam int HALF = 20;
	localparam int SEC = 2 * HALF;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic        wbCyc = 1'b0;
	logic        wbStb = 1'b0;
	logic        wbWe = 1'b0;
	logic [7:0]  wbAdr = 8'h00;
	logic [31:0] wbDat = 32'h0000_0000;
	logic [3:0]  wbSel = 4'hf, lanes = 4'hf;
	logic [19:0] rateValue = 20'h0_0000;
	logic [26:0] totalValue = 27'h000_0063;
	logic [31:0] wbDatO, got;
	logic [3:0]  keyPins, menuPrompt;
	logic [1:0]  swClosed, annunOn, dispLabel, codeCursor;
	logic [15:0] codeDigits;
	logic        wbAck, promptTotal;
	int          fails = 0, cmpCount = 0, seed = 75, on, lab, v;
	int          q[$] = '{4000, 3950, 3900, 3899, 3999};
	bit          act = 1'b0;

	always #20 mclk = ~mclk;

	das_top #(.HALF_SEC_CYCLES(HALF)) u_das_top (
		.mclk, .arst_n, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .rateValue, .totalValue,
		.keyPins, .alarmSwitchClosed(swClosed), .annunOn, .dispLabel,
		.menuPrompt, .promptTotal, .codeDigits, .codeCursor);
	das_panel u_das_panel (.mclk, .keyPins);

	// ********
	// tasks
	// ********
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		cmpCount++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbSel <= lanes;
		wbDat <= d;
		// no local limit: only the watchdog ends a wait for ack
		do begin
			@(posedge mclk);
		end while (wbAck !== 1'b1);
		chk("ack", wbAck, 1);
		got = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge mclk);
		chk("ackdrop", wbAck, 0);
	endtask

	task automatic samp(input int i);
		on = 0;
		lab = 0;
		repeat (SEC) begin
			@(posedge mclk);
			on += annunOn[i];
			lab += dispLabel == i + 1;
		end
	endtask

	function automatic bit hiRate(int val, bit was);
		return was ? val >= 4000 - 100 : val >= 4000;
	endfunction

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmpCount, fails);
		if (fails == 0 && cmpCount > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// whole run is near 1900 cycles
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		end_of_test;
	end

	// ********
	// scenarios
	// ********
	initial begin
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		wb(0, 8'h00, 0);
		chk("ctrl", got, 0);
		wb(0, 8'hf0, 0);
		chk("unmapped", got, 0);
		wb(0, 8'h08, 0);
		chk("stat", got, 32'h0000_1000);
		wb(1, 8'h10, 32'h0000_0019);
		wb(1, 8'h14, 32'h0000_0fa0);
		wb(1, 8'h18, 32'h0000_0064);
		for (int k = 0; k < 12; k++) begin
			v = k < 5 ? q[k] : 3800 + $unsigned($random(seed)) % 400;
			rateValue <= v[19:0];
			repeat (SEC) @(posedge mclk);
			act = hiRate(v, act);
			chk("sw0", swClosed[0], !act);
		end
		rateValue <= 20'h0_0fa0;
		repeat (SEC) @(posedge mclk);
		samp(0);
		chk("steady0", on, SEC);
		chk("label0", lab > 0 && lab < SEC, 1);
		u_das_panel.press(4'h1);
		chk("nosil", swClosed[0], 0);
		wb(1, 8'h1c, 32'h0003_0000);
		u_das_panel.press(4'h1);
		chk("sil", swClosed[0], 1);
		samp(0);
		chk("silflash", on > 0 && on < SEC, 1);
		repeat (3 * SEC) @(posedge mclk);
		chk("resume", swClosed[0], 0);
		samp(0);
		chk("silend", on, SEC);
		rateValue <= 20'h0_0000;
		$display("alarm one done");
		wb(1, 8'h20, 32'h0000_0002);
		wb(1, 8'h24, 32'h0000_0032);
		wb(1, 8'h28, 32'h0000_0064);
		wb(0, 8'h28, 0);
		chk("hys1", got, 0);
		wb(1, 8'h2c, 32'h0000_0003);
		wb(1, 8'h20, 32'h0000_0007);
		v = 50 - $unsigned($random(seed)) % 50;
		totalValue <= v[26:0];
		repeat (HALF + 4) @(posedge mclk);
		samp(1);
		chk("dly", swClosed[1], 0);
		chk("dlyflash", on > 0 && on < SEC, 1);
		repeat (3 * SEC) @(posedge mclk);
		chk("act1", swClosed[1], 1);
		samp(1);
		chk("steady1", on + lab, SEC);
		totalValue <= 27'h000_0033;
		repeat (SEC) @(posedge mclk);
		chk("clear1", swClosed[1], 0);
		$display("alarm two done");
		u_das_panel.press(4'h3);
		chk("locked", menuPrompt, 4'h1);
		wb(1, 8'h00, 32'h0000_0001);
		u_das_panel.press(4'h3);
		chk("open", menuPrompt, 4'h4);
		chk("pt1", promptTotal, 0);
		u_das_panel.press(4'h2);
		chk("sp2", menuPrompt, 4'h8);
		chk("pt2", promptTotal, 1);
		u_das_panel.press(4'h4);
		u_das_panel.press(4'h8);
		chk("exit", menuPrompt, 4'h1);
		wb(1, 8'h04, 32'h0000_0001);
		u_das_panel.press(4'h3);
		chk("code", menuPrompt, 4'h2);
		u_das_panel.press(4'h2);
		chk("digit", codeDigits, 16'h0001);
		u_das_panel.press(4'h1);
		chk("cursor", codeCursor, 2'h1);
		u_das_panel.press(4'h8);
		chk("good", menuPrompt, 4'h4);
		u_das_panel.press(4'h8);
		wb(1, 8'h04, 32'h0000_0005);
		u_das_panel.press(4'h3);
		u_das_panel.press(4'h8);
		chk("wrong", menuPrompt, 4'h1);
		totalValue <= 27'h000_0000;
		u_das_panel.press(4'h3);
		repeat (8 * SEC) @(posedge mclk);
		chk("wait", menuPrompt, 4'h2);
		repeat (4 * SEC) @(posedge mclk);
		chk("timeout", menuPrompt, 4'h1);
		chk("act2", swClosed[1], 1);
		arst_n <= 1'b0;
		repeat (4) @(posedge mclk);
		chk("rst", {swClosed, annunOn}, 4'h0);
		arst_n <= 1'b1;
		$display("menu and reset done");
		wb(1, 8'h1c, 32'h0000_0fff);
		wb(0, 8'h1c, 0);
		chk("dlymax", got[11:0], 12'he10);
		wb(1, 8'h14, 32'h0fff_ffff);
		wb(0, 8'h14, 0);
		chk("spmax", got, 32'h000f_423f);
		lanes = 4'h2;
		wb(1, 8'h14, 32'h0000_1200);
		lanes = 4'hf;
		wb(0, 8'h14, 0);
		chk("lanes", got, 32'h000f_123f);
		end_of_test;
	end
endmodule
